/* pkg/tpcs_pkg.sv */
// Overview of operation
// - start rising edge: busy, hold after 50 ns
// - first phase lasts 3.35 us
// - first phase gives 9 upper bits
// - lower seven dac bits always zero
// - second phase after settling, residue held, 9 bits
// - correction removes offset, merges 16-bit word
// - input returns to track at residue hold
// - overlap supports starts up to 166 kSPS
// - result is two's complement coded
// - busy low during whole conversion
`default_nettype none
package tpcs_pkg;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_PS     = 8000;
  localparam int HOLD_DELAY_PS     = 50000;
  localparam int PHASE1_PS         = 3350000;
  localparam int SETTLE_PS         = 200000;
  localparam int PHASE2_PS         = 1750000;
  localparam int THROUGHPUT_SPS    = 166000;
  // least times round up
  localparam int HOLD_DELAY_CYC    = (HOLD_DELAY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int PHASE1_CYC        = (PHASE1_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SETTLE_CYC        = (SETTLE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int PHASE2_CYC        = (PHASE2_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // ---------------------------------------------------------------
  // widths and coding
  // ---------------------------------------------------------------
  localparam int RES_W             = 16;
  localparam int PASS_W            = 9;
  localparam int DAC_LOW_W         = 7;
  localparam int CNT_W             = 10;
  localparam logic [8:0] RESIDUE_OFFSET = 9'h040;
  localparam logic [15:0] RESULT_RESET  = 16'h0000;

  typedef enum logic [2:0]
  {
    TPCS_IDLE   = 3'b000,
    TPCS_APERT  = 3'b001,
    TPCS_PASS1  = 3'b010,
    TPCS_SETTLE = 3'b011,
    TPCS_PASS2  = 3'b100,
    TPCS_MERGE  = 3'b101
  } tpcs_state_e;
endpackage
`default_nettype wire

/* rtl/tpcs_merge.sv */
`default_nettype none
module tpcs_merge
  import tpcs_pkg::*;
(
  input  wire logic [8:0]  i_coarse,
  input  wire logic [8:0]  i_residue,
  output logic      [15:0] o_word
);
  // ------------------------------------------------------------
  // error correction
  // ------------------------------------------------------------
  // offset binary sum; residue carries an offset so that first-pass
  // errors of either sign can be corrected
  // offset removal merge
  logic [16:0] sum_w;
  logic [16:0] diff_w;
  logic        under_w;
  logic        over_w;
  logic [15:0] bin_w;
  assign sum_w   = {1'b0, i_coarse, 7'h00} + {8'h00, i_residue};
  assign under_w = (sum_w < {8'h00, RESIDUE_OFFSET});
  assign diff_w  = sum_w - {8'h00, RESIDUE_OFFSET};
  assign over_w  = diff_w[16];
  // clamp both ends: a miss at full scale must not wrap the sign
  assign bin_w   = under_w ? 16'h0000 : (over_w ? 16'hFFFF : diff_w[15:0]);
  assign o_word = {~bin_w[15], bin_w[14:0]};
endmodule
`default_nettype wire

/* rtl/tpcs_sequencer.sv */
`default_nettype none
module tpcs_sequencer
  import tpcs_pkg::*;
(
  input  wire logic         i_clk_sys,
  input  wire logic         i_reset,
  input  wire logic         i_sample_trigger_n,
  input  wire logic [8:0]   i_flash_code,
  input  wire logic         i_chip_select_n,
  input  wire logic         i_read_n,
  input  wire logic         i_upper_byte_select,
  output logic              o_busy_n,
  output logic              o_input_hold,
  output logic              o_residue_hold,
  output logic [15:0]       o_dac_code,
  output logic [15:0]       o_data_word,
  output logic [7:0]        o_data_byte,
  output logic              o_data_oe
);
  import tpcs_pkg::*;

  tpcs_state_e       state_q;
  tpcs_state_e       state_d;
  logic [CNT_W-1:0]  cnt_q;
  logic [CNT_W-1:0]  cnt_d;
  logic              trig_q;
  logic [8:0]        coarse_q;
  logic [8:0]        residue_q;
  logic [15:0]       result_q;
  logic              busy_n_q;
  logic              in_hold_q;
  logic              res_hold_q;
  logic [15:0]       dac_q;
  logic [15:0]       word_q;
  logic [7:0]        byte_q;
  logic              oe_q;

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  // edge seen on a level already synchronous to our clock
  wire start_edge = i_sample_trigger_n & ~trig_q;
  wire cnt_done   = (cnt_q == '0);
  wire read_en    = ~i_chip_select_n & ~i_read_n;
  wire [15:0] merged_w;
  wire [7:0]  byte_sel_w = i_upper_byte_select ? result_q[15:8] : result_q[7:0];

  tpcs_merge u_merge
  (
    .i_coarse  (coarse_q),
    .i_residue (residue_q),
    .o_word    (merged_w)
  );

  // ------------------------------------------------------------
  // sequence control
  // ------------------------------------------------------------
  always_comb
  begin
    state_d = state_q;
    cnt_d   = cnt_done ? cnt_q : cnt_q - 1'b1;
    case (state_q)
      TPCS_IDLE:
      begin
        if (start_edge)
        begin
          state_d = TPCS_APERT;
          cnt_d   = CNT_W'(HOLD_DELAY_CYC - 1);
        end
      end
      TPCS_APERT:
        if (cnt_done)
        begin
          state_d = TPCS_PASS1;
          cnt_d   = CNT_W'(PHASE1_CYC - HOLD_DELAY_CYC - 1);
        end
      TPCS_PASS1:
        if (cnt_done)
        begin
          state_d = TPCS_SETTLE;
          cnt_d   = CNT_W'(SETTLE_CYC - 1);
        end
      TPCS_SETTLE:
        if (cnt_done)
        begin
          state_d = TPCS_PASS2;
          cnt_d   = CNT_W'(PHASE2_CYC - SETTLE_CYC - 1);
        end
      TPCS_PASS2:
        if (cnt_done)
          state_d = TPCS_MERGE;
      TPCS_MERGE:
        state_d = TPCS_IDLE;
      default:
        state_d = TPCS_IDLE;
    endcase
  end

  // ------------------------------------------------------------
  // state registers
  // ------------------------------------------------------------
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      state_q <= TPCS_IDLE;
      cnt_q   <= '0;
      trig_q  <= 1'b1;
    end
    else
    begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      trig_q  <= i_sample_trigger_n;
    end
  end

  // ------------------------------------------------------------
  // analog controls and data capture
  // ------------------------------------------------------------
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      busy_n_q   <= 1'b1;
      in_hold_q  <= 1'b0;
      res_hold_q <= 1'b0;
      coarse_q   <= '0;
      residue_q  <= '0;
      result_q   <= RESULT_RESET;
      dac_q      <= '0;
    end
    else
    begin
      busy_n_q   <= (state_d == TPCS_IDLE);
      in_hold_q  <= (state_d == TPCS_PASS1) || (state_d == TPCS_SETTLE);
      res_hold_q <= (state_d == TPCS_PASS2);
      if (state_q == TPCS_PASS1 && cnt_done)
      begin
        coarse_q <= i_flash_code;
        dac_q    <= {i_flash_code, {DAC_LOW_W{1'b0}}};
      end
      if (state_q == TPCS_PASS2 && cnt_done)
        residue_q <= i_flash_code;
      if (state_q == TPCS_MERGE)
        result_q <= merged_w;
    end
  end

  // ------------------------------------------------------------
  // read port
  // ------------------------------------------------------------
  // one cycle latency, outputs stay registered
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      word_q <= '0;
      byte_q <= '0;
      oe_q   <= 1'b0;
    end
    else
    begin
      oe_q   <= read_en;
      word_q <= result_q;
      byte_q <= byte_sel_w;
    end
  end

  assign o_busy_n       = busy_n_q;
  assign o_input_hold   = in_hold_q;
  assign o_residue_hold = res_hold_q;
  assign o_dac_code     = dac_q;
  assign o_data_word    = word_q;
  assign o_data_byte    = byte_q;
  assign o_data_oe      = oe_q;

  // ------------------------------------------------------------
  // check helpers
  // ------------------------------------------------------------
  // length of one input hold window, cleared while tracking
  logic [CNT_W-1:0]  hold_len_q;
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset || !in_hold_q)
      hold_len_q <= '0;
    else
      hold_len_q <= hold_len_q + 1'b1;
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_busy_on_start: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (state_q == TPCS_IDLE && start_edge) |=> !o_busy_n)
    else $error("busy not asserted after start");
  a_hold_after_apert: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (state_q == TPCS_IDLE && start_edge) |=> !o_input_hold ##7 o_input_hold)
    else $error("input hold timing wrong");
  a_pass1_length: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    $rose(o_input_hold) |-> o_input_hold [*8])
    else $error("first phase cut short");
  a_hold_window: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    $fell(o_input_hold) |-> hold_len_q == CNT_W'(PHASE1_CYC - HOLD_DELAY_CYC + SETTLE_CYC))
    else $error("input hold window length wrong");
  a_dac_low_zero: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    o_dac_code[6:0] == 7'h00)
    else $error("dac low bits not zero");
  a_track_resume: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    $rose(o_residue_hold) |-> !o_input_hold)
    else $error("input not tracking in residue hold");
  a_busy_covers: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (o_input_hold || o_residue_hold) |-> !o_busy_n)
    else $error("busy high during conversion");
  a_ignore_restart: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (state_q == TPCS_PASS1 && !cnt_done) |=> state_q == TPCS_PASS1)
    else $error("conversion disturbed");
  a_result_latched: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (state_q == TPCS_MERGE) |=> (result_q == $past(merged_w)) ##1 o_busy_n)
    else $error("result not latched");
endmodule
`default_nettype wire

/* testbench/tpcs_host_model.sv */
`default_nettype none
// --------------------
// host side bus model
// --------------------
module tpcs_host_model
(
  input  wire logic       i_clk_sys,
  input  wire logic [7:0] i_data_byte,
  input  wire logic       i_data_oe,
  output logic            o_trig_n,
  output logic            o_cs_n,
  output logic            o_rd_n,
  output logic            o_ube
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle bus, strobes released
  initial
  begin
    o_trig_n = 1'b1;
    o_cs_n   = 1'b1;
    o_rd_n   = 1'b1;
    o_ube    = 1'b0;
  end
  task automatic start_conv();
    @(posedge i_clk_sys) o_trig_n <= 1'b0;
    @(posedge i_clk_sys) o_trig_n <= 1'b1;
  endtask
  task automatic read_byte(input logic ube, output logic [7:0] b, output logic oe);
    @(posedge i_clk_sys);
    o_ube  <= ube;
    o_cs_n <= 1'b0;
    o_rd_n <= 1'b0;
    repeat (2) @(posedge i_clk_sys);
    #1;
    b  = i_data_byte;
    oe = i_data_oe;
    @(posedge i_clk_sys);
    o_cs_n <= 1'b1;
    o_rd_n <= 1'b1;
  endtask
endmodule
`default_nettype wire

/* testbench/two_pass_conversion_sequencer_test.sv */
`default_nettype none
module two_pass_conversion_sequencer_test;
  timeunit 1ns;
  timeprecision 1ps;
  import tpcs_pkg::*;
  logic        clk, rst, busy_n, ih, rh, oe, trig_n, cs_n, rd_n, ube;
  logic [8:0]  fc = 9'h000;
  logic [8:0]  fc_c, fc_r;
  logic [15:0] dac, dw;
  logic [7:0]  db;
  int          fails, checks, cyc, len;
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  tpcs_sequencer dut_u (.i_clk_sys(clk), .i_reset(rst), .i_sample_trigger_n(trig_n),
    .i_flash_code(fc), .i_chip_select_n(cs_n), .i_read_n(rd_n),
    .i_upper_byte_select(ube), .o_busy_n(busy_n), .o_input_hold(ih),
    .o_residue_hold(rh), .o_dac_code(dac), .o_data_word(dw), .o_data_byte(db),
    .o_data_oe(oe));
  tpcs_host_model host_u (.i_clk_sys(clk), .i_data_byte(db), .i_data_oe(oe),
    .o_trig_n(trig_n), .o_cs_n(cs_n), .o_rd_n(rd_n), .o_ube(ube));
  // ----------------
  // flash and timer
  // ----------------
  // flash output follows whichever pass is running
  always @(posedge clk)
  begin
    fc <= rh ? fc_r : fc_c;
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      fails++;
      results();
    end
  end
  // merged word: offset removed, sign bit flipped
  function automatic logic [15:0] f_exp(input logic [8:0] c, r);
    return ({c, 7'h00} + {7'h00, r} - {7'h00, RESIDUE_OFFSET}) ^ 16'h8000;
  endfunction
  task automatic cmp(input logic [15:0] g, e, input string m);
    checks++;
    if (g !== e)
    begin
      fails++;
      $display("FAIL %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic results();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic t_conv(input logic [8:0] c, r, input logic [15:0] e);
    int n;
    logic [7:0] b;
    logic o;
    fc_c = c;
    fc_r = r;
    host_u.start_conv();
    repeat (2) @(posedge clk);
    #1;
    cmp(16'(busy_n), 16'h0, "busy");
    repeat (HOLD_DELAY_CYC - 2) @(posedge clk);
    #1;
    cmp(16'(ih), 16'h0, "aperture");
    @(posedge clk);
    #1;
    cmp(16'(ih), 16'h1, "hold");
    n = HOLD_DELAY_CYC + 1;
    while (rh !== 1'b1 && n < 900)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    cmp(16'(n >= PHASE1_CYC), 16'h1, "phase one");
    cmp(16'(rh), 16'h1, "residue hold");
    cmp(16'(ih), 16'h0, "track");
    cmp(dac, {c, 7'h00}, "dac");
    while (busy_n !== 1'b1 && n < 900)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    len = n;
    cmp(16'(n <= (1000000000 / CLK_PERIOD_PS) * 1000 / THROUGHPUT_SPS), 16'h1, "rate");
    repeat (2) @(posedge clk);
    #1;
    cmp(dw, e, "word");
    host_u.read_byte(1'b1, b, o);
    cmp({8'h00, b}, {8'h00, e[15:8]}, "upper");
    cmp(16'(o), 16'h1, "oe");
    host_u.read_byte(1'b0, b, o);
    cmp({8'h00, b}, {8'h00, e[7:0]}, "lower");
    $display("conversion %h done", e);
  endtask
  task automatic t_ignore();
    int n;
    n = 0;
    fc_c = 9'h100;
    fc_r = 9'h100;
    host_u.start_conv();
    repeat (20) @(posedge clk);
    host_u.start_conv();
    while (busy_n !== 1'b1 && n < 900)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    cmp(16'(n < len - 15), 16'h1, "restart");
    repeat (30) @(posedge clk);
    #1;
    cmp(16'(busy_n), 16'h1, "idle");
    cmp(dw, f_exp(9'h100, 9'h100), "single");
    $display("ignore test done");
  endtask
  initial
  begin
    rst = 1'b1;
    fc_c = 9'h000;
    fc_r = 9'h000;
    fails = 0;
    checks = 0;
    cyc = 0;
    len = 0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    cmp(16'(busy_n), 16'h1, "reset");
    t_conv(9'h100, 9'h040, 16'h0000);
    t_conv(9'h000, 9'h040, 16'h8000);
    t_conv(9'h1FF, 9'h0BF, 16'h7FFF);
    t_conv(9'h0FF, 9'h0BF, 16'hFFFF);
    t_conv(9'h123, 9'h055, f_exp(9'h123, 9'h055));
    t_conv(9'h000, 9'h000, 16'h8000);
    t_conv(9'h1FF, 9'h1FF, 16'h7FFF);
    t_ignore();
    results();
  end
endmodule
`default_nettype wire
